// >>> hdl/mlcs_regs.v
`timescale 1ns/100ps
`include "mlcs_consts.vh"

// ************************************************************
// Register map of the bank
// ************************************************************
// LANE_LASER_DISABLE lane laser disable
//    10-0  One bit per network lane, 1 turns the laser off
//    15-11 Upper lanes, not fitted, read zero
// LOOPBACK_PATTERN_CONTROL loopback and pattern control
//    10    Host lane loopback, 1 returns host data to host
//    Other Pattern enables and selects, not fitted, read zero
// INTERFACE_FORMAT_SELECT interface format select, resets to 0009h
//    7-0   Format code, 01h clock recovery on, else bypass
//    15-8  Pattern, offset and threshold controls, read zero
// MODULE_STATE module state, read only
//    6     Fault
//    5     Ready
//    3     Transmitters off
//    1     Low power
//    Other Transient states, never shown
// RESERVED_WORD reserved, reads zero
// GLOBAL_ALARM_SUMMARY global summary, read only
//    15    Alarm line echo
//    13    Lane fault and status stages
//    12    Lane alarms and warnings
//    11-10 Module flag groups two and one
//    9     Enabled fault inputs
//    8     Enabled general status inputs
//    7     Enabled state inputs
//    4     Command block done
//    3     Enabled vendor flags
//    0     Alarm test bit
// LANE_ALARM_SUMMARY lane summary, read only
//    10-0  Per lane OR of enabled alarm and warning
//    15-11 Upper lanes, read zero
//
// Timing seen from the management port
//    Write taken on the strobe edge, stored at that edge
//    Control outputs follow one edge later
//    Status words lag their inputs by one edge
//    Read data and valid appear one edge after the strobe
//    Read data then holds until the next read strobe
//
// Limitations
//    No sticky flags: every summary bit is a live level
//    Writes to read-only words are dropped without notice
//    A read and a write in one cycle return the old value
//

// Functional notes
// - Lane 0-10 disable bit turns laser off
// - Lanes 11-15 disable bits have no function
// - Loopback bit 10 returns host lane data
// - Pattern checker/generator bits not implemented
// - Format 01h recovery on, 09h bypass default
// - Format register bits 15-8 not implemented
// - State bit 6 shows fault, one cycle behind its input
// - State bit 5 shows module ready
// - State bit 3 shows transmitters disabled
// - State bit 1 shows low power state
// - Transient state bits 0,2,4,7,8 read zero
// - Summary bit 13 ORs lane fault/status stages
// - Summary bit 12 ORs lane alarms/warnings
// - Summary bit 11 ORs group-two module flags
// - Summary bit 9 ORs enabled fault inputs
// - Summary bit 8 ORs enabled status inputs
// - Summary bit 7 ORs enabled state inputs
// - Summary bit 4 set on command completion
// - Summary bit 3 ORs enabled vendor flags
// - Summary bit 0 mirrors alarm test bit
// - Lane summary bit ORs lane's enabled flags
// - Lane summary bits 11-15 not implemented
module mlcs_regs (
   input  wire        mclk_i,
   input  wire        arst_n_i,
   // Register access from the management port
   input  wire [15:0] reg_addr_i,
   input  wire [15:0] reg_wdata_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   output reg  [15:0] reg_rdata_o,
   output reg         reg_rvalid_o,
   output wire        reg_hit_o,
   // Module condition inputs
   input  wire        module_fault_state_i,
   input  wire        module_ready_state_i,
   input  wire        low_power_i,
   input  wire        tx_global_disable_i,
   input  wire        global_alarm_line_i,
   input  wire        global_alarm_test_i,
   // Network lane flags, two per lane: alarm in even, warning in odd
   input  wire [21:0] lane_tx_aw_i,
   input  wire [21:0] lane_rx_aw_i,
   input  wire [21:0] lane_tx_aw_en_i,
   input  wire [21:0] lane_rx_aw_en_i,
   input  wire [10:0] lane_tx_stage_i,
   input  wire [10:0] lane_rx_stage_i,
   // Module-wide flag groups, with enables for all but mod_aw1_i and mod_aw2_i
   input  wire [7:0]  mod_aw1_i,
   input  wire [7:0]  mod_aw2_i,
   input  wire [7:0]  module_fault_state_in_i,
   input  wire [7:0]  module_fault_state_en_i,
   input  wire [7:0]  mod_gen_stat_i,
   input  wire [7:0]  mod_gen_stat_en_i,
   input  wire [7:0]  mod_state_in_i,
   input  wire [7:0]  mod_state_en_i,
   input  wire [7:0]  vendor_fault_alarm_warning_status_flags_i,
   input  wire [7:0]  vendor_fault_alarm_warning_status_flags_en_i,
   input  wire        cmd_block_done_ok_i,
   input  wire        cmd_block_done_fail_i,
   // Controls toward the optics and electrical path
   output reg  [10:0] laser_disable_o,
   output reg         host_side_loopback_o,
   output reg  [7:0]  interface_format_o,
   output reg         clock_recovery_on_o
);

   // ************************************************************
   // Helpers
   // ************************************************************

   // OR of flags gated by their enables
   function any_enabled;
      input [7:0] flags;
      input [7:0] enables;
      begin
         any_enabled = |(flags & enables);
      end
   endfunction

   // Per-lane OR of enabled alarm and warning pairs;
   // used for both directions and for the summary bit
   function [10:0] lane_or;
      input [21:0] flags;
      input [21:0] enables;
      reg   [21:0] gated;
      integer      i;
      begin
         gated   = flags & enables;
         lane_or = 11'h000;
         for (i = 0; i < `MLCS_LANE_COUNT; i = i + 1) begin
            lane_or[i] = gated[2*i] | gated[2*i+1];
         end
      end
   endfunction

   // ************************************************************
   // Storage
   // ************************************************************
   reg [15:0] lane_laser_disable_reg;
   reg [15:0] loopback_pattern_control_reg;
   reg [15:0] interface_format_select_reg;
   reg [15:0] module_state_reg;
   reg [15:0] global_alarm_summary_reg;
   reg [15:0] lane_alarm_summary_reg;

   reg [15:0] module_state_next;
   reg [15:0] global_alarm_summary_next;
   reg [15:0] lane_alarm_summary_next;
   reg [15:0] rdata_next;

   // Per-lane summaries, shared by the lane word and bit 12
   wire [10:0] lane_tx_sum;
   wire [10:0] lane_rx_sum;
   wire        tx_all_off;

   // ************************************************************
   // Address decode
   // ************************************************************
   wire sel_lane_dis = (reg_addr_i == `MLCS_ADDR_LANE_DIS);
   wire sel_loopback = (reg_addr_i == `MLCS_ADDR_LOOPBACK);
   wire sel_if_fmt   = (reg_addr_i == `MLCS_ADDR_IF_FORMAT);
   wire sel_state    = (reg_addr_i == `MLCS_ADDR_MOD_STATE);
   wire sel_rsvd     = (reg_addr_i == `MLCS_ADDR_RSVD_WORD);
   wire sel_glb      = (reg_addr_i == `MLCS_ADDR_GLB_SUMMARY);
   wire sel_lane_sum = (reg_addr_i == `MLCS_ADDR_LANE_SUMMARY);

   // Tells the serial front end whether this bank owns the address;
   // the reserved word counts as owned so it answers zero here
   assign reg_hit_o = sel_lane_dis | sel_loopback | sel_if_fmt | sel_state |
                      sel_rsvd | sel_glb | sel_lane_sum;

   // ************************************************************
   // Writable registers
   // ************************************************************

   // Only implemented bits are stored, so unsupported ones stay zero.
   // One process per word keeps a slip in one decode away from the rest.
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lane_laser_disable_reg <= `MLCS_RST_LANE_DIS;
      end else if (reg_wr_i && sel_lane_dis) begin
         lane_laser_disable_reg <= reg_wdata_i & `MLCS_MASK_LANE_DIS;
      end
   end

   // Pattern enables and selects dropped, only loopback kept
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         loopback_pattern_control_reg <= `MLCS_RST_LOOPBACK;
      end else if (reg_wr_i && sel_loopback) begin
         loopback_pattern_control_reg <= reg_wdata_i & `MLCS_MASK_LOOPBACK;
      end
   end

   // Upper format bits dropped; the code is stored as given
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         interface_format_select_reg <= `MLCS_RST_IF_FORMAT;
      end else if (reg_wr_i && sel_if_fmt) begin
         interface_format_select_reg <= reg_wdata_i & `MLCS_MASK_IF_FORMAT;
      end
   end

   // ************************************************************
   // Control outputs
   // ************************************************************

   // Registered one cycle after the write so the optics see clean levels;
   // lasers come up enabled out of reset, as the stored word says
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         laser_disable_o <= 11'h000;
      end else begin
         laser_disable_o <= lane_laser_disable_reg[`MLCS_LANE_MSB:0];
      end
   end

   // Loopback stays off until the host asks for it
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         host_side_loopback_o <= 1'b0;
      end else begin
         host_side_loopback_o <= loopback_pattern_control_reg[`MLCS_LOOPBACK_BIT];
      end
   end

   // Format code and the recovery switch derived from it
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         interface_format_o   <= `MLCS_FMT_BYPASS;
         clock_recovery_on_o  <= 1'b0;
      end else begin
         interface_format_o   <= interface_format_select_reg[`MLCS_IF_FMT_MSB:0];
         // Any code other than 01h keeps recovery bypassed, the low-power choice
         clock_recovery_on_o  <= (interface_format_select_reg[`MLCS_IF_FMT_MSB:0] ==
                                  `MLCS_FMT_CLK_RECOVERY);
      end
   end

   // ************************************************************
   // Status gathering
   // ************************************************************

   // Transmitters count as off when globally disabled or every lane is off
   assign tx_all_off  = tx_global_disable_i | (&lane_laser_disable_reg[`MLCS_LANE_MSB:0]);
   assign lane_tx_sum = lane_or(lane_tx_aw_i, lane_tx_aw_en_i);
   assign lane_rx_sum = lane_or(lane_rx_aw_i, lane_rx_aw_en_i);

   // Module state word; transient states never shown
   always @* begin
      module_state_next                        = `MLCS_RST_STATUS;
      module_state_next[`MLCS_ST_FAULT_BIT]    = module_fault_state_i;
      module_state_next[`MLCS_ST_READY_BIT]    = module_ready_state_i;
      module_state_next[`MLCS_ST_TXOFF_BIT]    = tx_all_off;
      module_state_next[`MLCS_ST_LOWPWR_BIT]   = low_power_i;
   end

   // Global summary word
   always @* begin
      global_alarm_summary_next = `MLCS_RST_STATUS;
      global_alarm_summary_next[`MLCS_GS_GLB_LINE_BIT]  = global_alarm_line_i;
      global_alarm_summary_next[`MLCS_GS_NET_FS_BIT]    = |{lane_tx_stage_i, lane_rx_stage_i};
      global_alarm_summary_next[`MLCS_GS_NET_AW_BIT]    = |{lane_tx_sum, lane_rx_sum};
      global_alarm_summary_next[`MLCS_GS_MOD_AW2_BIT]   = |mod_aw2_i;
      global_alarm_summary_next[`MLCS_GS_MOD_AW1_BIT]   = |mod_aw1_i;
      global_alarm_summary_next[`MLCS_GS_MODULE_FAULT_STATE_BIT] = any_enabled(module_fault_state_in_i,
                                                                      module_fault_state_en_i);
      global_alarm_summary_next[`MLCS_GS_GEN_STAT_BIT]  = any_enabled(mod_gen_stat_i,
                                                                      mod_gen_stat_en_i);
      global_alarm_summary_next[`MLCS_GS_MOD_STATE_BIT] = any_enabled(mod_state_in_i,
                                                                      mod_state_en_i);
      global_alarm_summary_next[`MLCS_GS_CMD_DONE_BIT]  = cmd_block_done_ok_i |
                                                          cmd_block_done_fail_i;
      global_alarm_summary_next[`MLCS_GS_VENDOR_BIT]    = any_enabled(vendor_fault_alarm_warning_status_flags_i,
                                                                      vendor_fault_alarm_warning_status_flags_en_i);
      global_alarm_summary_next[`MLCS_GS_ALM_TEST_BIT]  = global_alarm_test_i;
   end

   // Lane summary word, upper lanes held at zero
   always @* begin
      lane_alarm_summary_next = {5'h00, lane_tx_sum | lane_rx_sum};
   end

   // Status words refresh every cycle, one cycle behind their inputs.
   // The flop keeps a read from catching a word mid-change.
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         module_state_reg <= `MLCS_RST_STATUS;
      end else begin
         module_state_reg <= module_state_next & `MLCS_MASK_MOD_STATE;
      end
   end

   // Global summary, masked to the fitted bits
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         global_alarm_summary_reg <= `MLCS_RST_STATUS;
      end else begin
         global_alarm_summary_reg <= global_alarm_summary_next & `MLCS_MASK_GLB_SUMMARY;
      end
   end

   // Lane summary, masked to the fitted lanes
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lane_alarm_summary_reg <= `MLCS_RST_STATUS;
      end else begin
         lane_alarm_summary_reg <= lane_alarm_summary_next & `MLCS_MASK_LANE_SUMMARY;
      end
   end

   // ************************************************************
   // Read path
   // ************************************************************

   // Unmapped and reserved words answer zero.
   // The selects are one-hot by construction, so the order of the
   // items below carries no priority.
   always @* begin
      rdata_next = 16'h0000;
      case (1'b1)
         sel_lane_dis: begin
            rdata_next = lane_laser_disable_reg;
         end
         sel_loopback: begin
            rdata_next = loopback_pattern_control_reg;
         end
         sel_if_fmt: begin
            rdata_next = interface_format_select_reg;
         end
         sel_state: begin
            rdata_next = module_state_reg;
         end
         sel_glb: begin
            rdata_next = global_alarm_summary_reg;
         end
         sel_lane_sum: begin
            rdata_next = lane_alarm_summary_reg;
         end
         default: begin
            rdata_next = 16'h0000;
         end
      endcase
   end

   // Data held until the next read; valid pulses for one cycle.
   // Holding the data lets a slow serial front end shift it out
   // at leisure without a buffer of its own.
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reg_rdata_o  <= 16'h0000;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= rdata_next;
         end
      end
   end

endmodule

// >>> hdl/mlcs_consts.vh
`ifndef MLCS_CONSTS_VH
`define MLCS_CONSTS_VH

// ************************************************************
// Register addresses on the management port
// ************************************************************
`define MLCS_ADDR_LANE_DIS     16'hA013
`define MLCS_ADDR_LOOPBACK     16'hA014
`define MLCS_ADDR_IF_FORMAT    16'hA015
`define MLCS_ADDR_MOD_STATE    16'hA016
`define MLCS_ADDR_RSVD_WORD    16'hA017
`define MLCS_ADDR_GLB_SUMMARY  16'hA018
`define MLCS_ADDR_LANE_SUMMARY 16'hA019

// ************************************************************
// Reset values
// ************************************************************
`define MLCS_RST_LANE_DIS      16'h0000
`define MLCS_RST_LOOPBACK      16'h0000
`define MLCS_RST_IF_FORMAT     16'h0009
`define MLCS_RST_STATUS        16'h0000

// ************************************************************
// Implemented bit masks; everything else reads zero
// ************************************************************
`define MLCS_MASK_LANE_DIS     16'h07FF
`define MLCS_MASK_LOOPBACK     16'h0400
`define MLCS_MASK_IF_FORMAT    16'h00FF
`define MLCS_MASK_MOD_STATE    16'h006A
`define MLCS_MASK_GLB_SUMMARY  16'hBF99
`define MLCS_MASK_LANE_SUMMARY 16'h07FF

// ************************************************************
// Field positions
// ************************************************************
`define MLCS_LANE_COUNT        11
`define MLCS_LANE_MSB          10
`define MLCS_LOOPBACK_BIT      10
`define MLCS_IF_FMT_MSB        7
`define MLCS_ST_FAULT_BIT      6
`define MLCS_ST_READY_BIT      5
`define MLCS_ST_TXOFF_BIT      3
`define MLCS_ST_LOWPWR_BIT     1
`define MLCS_GS_GLB_LINE_BIT   15
`define MLCS_GS_NET_FS_BIT     13
`define MLCS_GS_NET_AW_BIT     12
`define MLCS_GS_MOD_AW2_BIT    11
`define MLCS_GS_MOD_AW1_BIT    10
`define MLCS_GS_MODULE_FAULT_STATE_BIT  9
`define MLCS_GS_GEN_STAT_BIT   8
`define MLCS_GS_MOD_STATE_BIT  7
`define MLCS_GS_CMD_DONE_BIT   4
`define MLCS_GS_VENDOR_BIT     3
`define MLCS_GS_ALM_TEST_BIT   0

// ************************************************************
// Interface format codes
// ************************************************************
`define MLCS_FMT_CLK_RECOVERY  8'h01
`define MLCS_FMT_BYPASS        8'h09

`endif

// >>> sim/mlcs_regs_properties.sv
`timescale 1ns/100ps
`include "mlcs_consts.vh"

// ************************************************************
// Port checks of the lane control register bank
// ************************************************************
module mlcs_regs_properties (
   input logic        mclk_i,
   input logic        arst_n_i,
   input logic [15:0] reg_addr_i,
   input logic [15:0] reg_wdata_i,
   input logic        reg_wr_i,
   input logic        reg_rd_i,
   input logic [15:0] reg_rdata_o,
   input logic        reg_rvalid_o,
   input logic        reg_hit_o,
   input logic        module_fault_state_i,
   input logic        module_ready_state_i,
   input logic        low_power_i,
   input logic        tx_global_disable_i,
   input logic [21:0] lane_tx_aw_i,
   input logic [21:0] lane_rx_aw_i,
   input logic [21:0] lane_tx_aw_en_i,
   input logic [21:0] lane_rx_aw_en_i,
   input logic [10:0] laser_disable_o,
   input logic        host_side_loopback_o,
   input logic [7:0]  interface_format_o,
   input logic        clock_recovery_on_o
);
   logic [10:0] lane_or;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);

   // Expected lane summary; alarm sits in the even bit, warning in the odd
   always_comb begin
      for (int n = 0; n < 11; n++) begin
         lane_or[n] = |(lane_tx_aw_i[2*n +: 2] & lane_tx_aw_en_i[2*n +: 2]) |
                      |(lane_rx_aw_i[2*n +: 2] & lane_rx_aw_en_i[2*n +: 2]);
      end
   end

   chk_read_answer: assert property (reg_rvalid_o == $past(reg_rd_i))
      else $error("read answer not one cycle after read");
   chk_rdata_holds: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
      else $error("read data moved without a read");
   chk_laser_write: assert property (
      reg_wr_i && reg_addr_i == `MLCS_ADDR_LANE_DIS |-> ##2 laser_disable_o == $past(reg_wdata_i[10:0], 2))
      else $error("laser controls do not follow the write");
   chk_loop_write: assert property (
      reg_wr_i && reg_addr_i == `MLCS_ADDR_LOOPBACK |-> ##2 host_side_loopback_o == $past(reg_wdata_i[10], 2))
      else $error("loopback does not follow the write");
   chk_format_write: assert property (
      reg_wr_i && reg_addr_i == `MLCS_ADDR_IF_FORMAT |-> ##2 interface_format_o == $past(reg_wdata_i[7:0], 2))
      else $error("format output does not follow the write");
   chk_clock_recovery: assert property (
      clock_recovery_on_o == (interface_format_o == `MLCS_FMT_CLK_RECOVERY))
      else $error("clock recovery does not match format code");
   chk_hit_decode: assert property (
      reg_hit_o == (reg_addr_i >= `MLCS_ADDR_LANE_DIS && reg_addr_i <= `MLCS_ADDR_LANE_SUMMARY))
      else $error("address hit does not match the mapped range");
   chk_state_read: assert property (
      reg_rd_i && reg_addr_i == `MLCS_ADDR_MOD_STATE && $past(arst_n_i) |=> reg_rdata_o == {9'h000,
      $past(module_fault_state_i, 2), $past(module_ready_state_i, 2), 1'b0,
      $past(tx_global_disable_i, 2) | (&$past(laser_disable_o)), 1'b0,
      $past(low_power_i, 2), 1'b0})
      else $error("module state word wrong");
   chk_lane_summary: assert property (
      reg_rd_i && reg_addr_i == `MLCS_ADDR_LANE_SUMMARY && $past(arst_n_i) |=> reg_rdata_o == {5'h00, $past(lane_or, 2)})
      else $error("lane summary word wrong");
   chk_lane_upper: assert property (
      reg_rd_i && reg_addr_i == `MLCS_ADDR_LANE_DIS |=> reg_rdata_o[15:11] == 5'h00)
      else $error("upper lane disable bits not zero");
   chk_loop_unused: assert property (
      reg_rd_i && reg_addr_i == `MLCS_ADDR_LOOPBACK |=> (reg_rdata_o & 16'hFBFF) == 16'h0000)
      else $error("pattern bits of loopback word not zero");
   chk_rsvd_word: assert property (
      reg_rd_i && reg_addr_i == `MLCS_ADDR_RSVD_WORD |=> reg_rdata_o == 16'h0000)
      else $error("reserved word not zero");
endmodule

// >>> sim/mlcs_host_model.sv
`timescale 1ns/100ps

// ************************************************************
// Host management controller on the register port
// ************************************************************
module mlcs_host_model (
   input  logic        mclk_i,
   input  logic [15:0] reg_rdata_i,
   input  logic        reg_rvalid_i,
   output logic [15:0] reg_addr_o,
   output logic [15:0] reg_wdata_o,
   output logic        reg_wr_o,
   output logic        reg_rd_o
);
   // Quiet bus at time zero
   initial begin
      reg_addr_o = 16'h0000;
      reg_wdata_o = 16'h0000;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
   end

   // Idle lines are inverted so stale values never look valid
   task automatic wr_word(input logic [15:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge mclk_i);
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask

   // A missing answer comes back as unknown, so it never matches
   task automatic rd_word(input logic [15:0] a, output logic [15:0] d);
      @(posedge mclk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge mclk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      @(negedge mclk_i);
      d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 16'hXXXX;
   endtask
endmodule

// >>> sim/testbench.sv
`timescale 1ns/100ps
`include "mlcs_consts.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end

// ************************************************************
// Self-checking bench of the lane control register bank
// ************************************************************
module testbench;
   logic         mclk_i = 1'b0;
   logic         arst_n_i = 1'b0;
   logic [197:0] iv = '0;
   logic [15:0]  addr, wdata, rdata, d;
   logic         wr, rd, rvalid, loopb, clkrec;
   logic [10:0]  laser;
   logic [7:0]   fmt;
   int           errors = 0;
   int           num_checks = 0;
   int           cyc = 0;
   // Two input bits to raise, word (state, summary, lanes) and its value
   int t [22][4] = '{'{0,0,0,'h40}, '{1,1,0,'h20}, '{2,2,0,'h2}, '{3,3,0,'h8}, '{4,4,1,'h8000},
      '{5,5,1,'h1}, '{6,6,1,'h10}, '{7,7,1,'h10}, '{8,52,2,'h1}, '{29,73,2,'h400}, '{39,83,2,'h10},
      '{8,8,2,0}, '{96,96,1,'h2000}, '{117,117,1,'h2000}, '{118,118,1,'h400}, '{133,133,1,'h800},
      '{134,142,1,'h200}, '{141,141,1,0}, '{150,158,1,'h100}, '{173,181,1,'h80}, '{182,190,1,'h8},
      '{197,197,1,0}};

   mlcs_regs u_dut (
      .mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .reg_hit_o(),
      .module_fault_state_i(iv[0]), .module_ready_state_i(iv[1]), .low_power_i(iv[2]),
      .tx_global_disable_i(iv[3]), .global_alarm_line_i(iv[4]), .global_alarm_test_i(iv[5]),
      .cmd_block_done_ok_i(iv[6]), .cmd_block_done_fail_i(iv[7]), .lane_tx_aw_i(iv[29:8]),
      .lane_rx_aw_i(iv[51:30]), .lane_tx_aw_en_i(iv[73:52]), .lane_rx_aw_en_i(iv[95:74]),
      .lane_tx_stage_i(iv[106:96]), .lane_rx_stage_i(iv[117:107]), .mod_aw1_i(iv[125:118]),
      .mod_aw2_i(iv[133:126]), .module_fault_state_in_i(iv[141:134]), .module_fault_state_en_i(iv[149:142]),
      .mod_gen_stat_i(iv[157:150]), .mod_gen_stat_en_i(iv[165:158]), .mod_state_in_i(iv[173:166]),
      .mod_state_en_i(iv[181:174]), .vendor_fault_alarm_warning_status_flags_i(iv[189:182]), .vendor_fault_alarm_warning_status_flags_en_i(iv[197:190]),
      .laser_disable_o(laser), .host_side_loopback_o(loopb), .interface_format_o(fmt),
      .clock_recovery_on_o(clkrec));

   mlcs_host_model u_host (.mclk_i(mclk_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
      .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));

   task automatic wrap_up();
      $display("Checks %0d, errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic rchk(input logic [15:0] a, input logic [15:0] e);
      u_host.rd_word(a, d);
      `CHK(d, e)
   endtask

   task automatic wrc(input logic [15:0] a, input logic [15:0] w, input logic [15:0] e);
      u_host.wr_word(a, w);
      rchk(a, e);
   endtask

   // Clock and hang guard; the run needs well under a thousand cycles
   initial forever #10 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors++;
         wrap_up();
      end
   end

   initial begin
      logic [197:0] v;
      logic [15:0]  e;
      repeat (8) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      // Reset image of the whole bank and of the controls
      for (int a = 0; a < 7; a++) begin
         rchk(16'hA013 + 16'(a), (a == 2) ? 16'h0009 : 16'h0000);
      end
      `CHK({laser, loopb, fmt, clkrec}, {11'h000, 1'b0, 8'h09, 1'b0})
      // One source at a time into the state and summary words
      for (int i = 0; i < 22; i++) begin
         v = '0;
         v[t[i][0]] = 1'b1;
         v[t[i][1]] = 1'b1;
         @(posedge mclk_i);
         iv <= v;
         for (int k = 0; k < 3; k++) begin
            e = (k == t[i][2]) ? 16'(t[i][3]) : (k == 1 && t[i][2] == 2 && t[i][3] != 0) ? 16'h1000 : 16'h0000;
            rchk(16'hA016 + 16'(k + (k > 0)), e);
         end
      end
      @(posedge mclk_i);
      iv <= '0;
      // Writable words, unused bits and the controls behind them
      wrc(`MLCS_ADDR_LANE_DIS, 16'hFFFF, 16'h07FF);
      `CHK(laser, 11'h7FF)
      rchk(`MLCS_ADDR_MOD_STATE, 16'h0008);
      wrc(`MLCS_ADDR_LANE_DIS, 16'hFBFF, 16'h03FF);
      `CHK(laser, 11'h3FF)
      rchk(`MLCS_ADDR_MOD_STATE, 16'h0000);
      wrc(`MLCS_ADDR_LOOPBACK, 16'hFFFF, 16'h0400);
      `CHK(loopb, 1'b1)
      wrc(`MLCS_ADDR_LOOPBACK, 16'hFBFF, 16'h0000);
      `CHK(loopb, 1'b0)
      wrc(`MLCS_ADDR_IF_FORMAT, 16'hFF01, 16'h0001);
      `CHK({fmt, clkrec}, {8'h01, 1'b1})
      wrc(`MLCS_ADDR_IF_FORMAT, 16'h0009, 16'h0009);
      `CHK({fmt, clkrec}, {8'h09, 1'b0})
      // Read-only, reserved and unmapped words ignore writes
      for (int a = 3; a < 8; a++) begin
         wrc(16'hA013 + 16'(a), 16'hFFFF, 16'h0000);
      end
      wrap_up();
   end
endmodule

bind mlcs_regs mlcs_regs_properties u_props (.*);
